/* File: hw/trw_consts.vh */
`ifndef TRW_CONSTS_VH
`define TRW_CONSTS_VH
// register byte offsets
`define TRW_OFS_CMD0 8'h00
`define TRW_OFS_CMD1 8'h04
`define TRW_OFS_CTRL 8'h08
`define TRW_OFS_LMAX 8'h0C
`define TRW_OFS_LMIN 8'h10
`define TRW_OFS_MODE 8'h14
`define TRW_OFS_BLEN 8'h18
`define TRW_OFS_STAT 8'h1C
`define TRW_OFS_SENSE 8'h20
`define TRW_OFS_INFO 8'h24
// field positions
`define TRW_CTRL_START 0
`define TRW_CTRL_CLRDONE 1
`define TRW_MODE_FIXED 0
`define TRW_MODE_BUFFERED 1
`define TRW_CDB_FIXED 8
`define TRW_STAT_BUSY 0
`define TRW_STAT_DONE 1
`define TRW_STAT_CHECK 2
// reset values
`define TRW_RST_LMAX 24'h000000
`define TRW_RST_LMIN 16'h0001
`define TRW_RST_BLEN 24'h000200
// operation codes
`define TRW_OP_READ 8'h08
`define TRW_OP_WRITE 8'h0A
// sense keys
`define TRW_KEY_NONE 4'h0
`define TRW_KEY_MEDIUM 4'h3
`define TRW_KEY_ILLEGAL 4'h5
`define TRW_KEY_VOLOVF 4'hD
// bus responses
`define TRW_RESP_OKAY 2'h0
`define TRW_RESP_SLVERR 2'h2
`endif

/* File: hw/trw_exec.v */
// What this block does
// - fixed bit selects length meaning and fixed or variable blocks
// - variable read moves one block, length is allocated byte maximum
// - variable read length mismatch gives check, ili, valid, requested minus actual
// - block longer than request sets ili with residue zero when NEG_RESIDUE is 0
// - never send more than length bytes; end past the block
// - fixed read counts blocks, only allowed in fixed block mode
// - fixed mode when limits equal or mode select fixed; length from there
// - fixed bit against current or unimplemented mode gives illegal request
// - fixed read sends block length times count, ends after last block
// - fixed read wrong length block: ili, valid, residue, stop after it
// - filemark gives check and filemark bit; fixed adds valid and residue
// - physical end during read: eom, medium error, fixed adds residue
// - zero length moves nothing and completes good
// - write opcode stores initiator blocks at current position
// - variable write length must be within limits else illegal request
// - fixed write counts blocks, only in fixed mode, ends after them
// - early warning on write: check, eom, volume overflow if buffer holds data
// - unbuffered fixed write reports requested minus blocks written
// - buffered fixed write reports unreceived plus buffered blocks
// - read opcode is recognised
// - equal limits mean fixed only; zero maximum means no upper limit
`timescale 1ns/1ps
`include "trw_consts.vh"
module trw_exec #(
    parameter NEG_RESIDUE = 0,
    parameter FIXED_IMPL = 1,
    parameter VAR_IMPL = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [7:0] ini_rd_data,
    output wire ini_rd_valid,
    input wire ini_rd_ready,
    input wire [7:0] ini_wr_data,
    input wire ini_wr_valid,
    output wire ini_wr_ready,
    input wire [7:0] med_rd_data,
    input wire med_rd_valid,
    input wire med_rd_last,
    input wire med_rd_fm,
    output wire med_rd_ready,
    output wire [7:0] med_wr_data,
    output wire med_wr_valid,
    output wire med_wr_last,
    input wire med_wr_ready,
    input wire [23:0] med_buf_blocks,
    input wire med_ew_pin,
    input wire med_eom_pin,
    output wire med_start,
    output wire med_is_write,
    output wire cmd_busy,
    output wire cmd_check
);
    localparam S_IDLE = 3'd0;
    localparam S_DEC = 3'd1;
    localparam S_RD = 3'd2;
    localparam S_WR = 3'd3;
    localparam S_DRAIN = 3'd4;

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `TRW_OFS_INFO);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    reg aw_q, w_q, bv_q, rv_q;
    reg [7:0] awa_q;
    reg [31:0] wd_q, rd_q;
    reg [3:0] ws_q;
    reg [1:0] br_q, rr_q;
    reg [31:0] cmd0_q;
    reg [15:0] cmd1_q;
    reg [23:0] lmax_q, blen_q;
    reg [15:0] lmin_q;
    reg mfix_q, mbuf_q, start_q, clrdone_q;
    reg [2:0] st_q;
    reg busy_q, done_q, chk_q, ili_q, eom_q, fm_q, val_q;
    reg [3:0] key_q;
    reg [31:0] info_q;
    reg [23:0] blk_q, tot_q, good_q, rcv_q;
    reg ov_q, mv_q, ml_q, mst_q, mwr_q;
    reg [7:0] od_q, md_q;
    reg [1:0] ew_s, eom_s;

    // two-stage synchronisers for the medium sensor lines
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ew_s <= 2'b00;
            eom_s <= 2'b00;
        end
        else
        begin
            ew_s <= {ew_s[0], med_ew_pin};
            eom_s <= {eom_s[0], med_eom_pin};
        end
    end

    wire ew = ew_s[1];
    wire eom = eom_s[1];
    wire [7:0] opcode = cmd0_q[7:0];
    wire fixed = cmd0_q[`TRW_CDB_FIXED];
    wire [23:0] xfer = {cmd0_q[23:16], cmd0_q[31:24], cmd1_q[7:0]};
    wire fix_mode = (lmax_q == {8'h00, lmin_q}) || mfix_q;
    wire [23:0] cur_len = mfix_q ? blen_q : lmax_q;
    wire [23:0] wblen = fixed ? cur_len : xfer;
    wire [23:0] wtarget = fixed ? xfer : 24'h000001;
    wire len_ok = (xfer >= {8'h00, lmin_q})
                  && ((lmax_q == 24'h000000) || (xfer <= lmax_q));
    wire [31:0] blk_res = {8'h00, xfer} - {8'h00, good_q};
    wire [31:0] mg_cmd1 = merge({16'h0000, cmd1_q}, wd_q, ws_q);
    wire [31:0] mg_lmax = merge({8'h00, lmax_q}, wd_q, ws_q);
    wire [31:0] mg_lmin = merge({16'h0000, lmin_q}, wd_q, ws_q);
    wire [31:0] mg_blen = merge({8'h00, blen_q}, wd_q, ws_q);

    // axi4-lite slave: address and data taken in either order
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    wire do_wr = aw_q && w_q && !bv_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= `TRW_RESP_OKAY;
            awa_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            cmd0_q <= 32'h00000000;
            cmd1_q <= 16'h0000;
            lmax_q <= `TRW_RST_LMAX;
            lmin_q <= `TRW_RST_LMIN;
            blen_q <= `TRW_RST_BLEN;
            mfix_q <= 1'b0;
            mbuf_q <= 1'b0;
            start_q <= 1'b0;
            clrdone_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            clrdone_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (bv_q && s_axi_bready)
                bv_q <= 1'b0;
            if (do_wr)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                br_q <= mapped(awa_q) ? `TRW_RESP_OKAY : `TRW_RESP_SLVERR;
                // command and config stay frozen while a command runs
                case (awa_q)
                    `TRW_OFS_CMD0:
                        if (!busy_q)
                            cmd0_q <= merge(cmd0_q, wd_q, ws_q);
                    `TRW_OFS_CMD1:
                        if (!busy_q)
                            cmd1_q <= mg_cmd1[15:0];
                    `TRW_OFS_CTRL:
                    begin
                        start_q <= ws_q[0] && wd_q[`TRW_CTRL_START];
                        clrdone_q <= ws_q[0] && wd_q[`TRW_CTRL_CLRDONE];
                    end
                    `TRW_OFS_LMAX:
                        if (!busy_q)
                            lmax_q <= mg_lmax[23:0];
                    `TRW_OFS_LMIN:
                        if (!busy_q)
                            lmin_q <= mg_lmin[15:0];
                    `TRW_OFS_MODE:
                        if (!busy_q && ws_q[0])
                        begin
                            mfix_q <= wd_q[`TRW_MODE_FIXED];
                            mbuf_q <= wd_q[`TRW_MODE_BUFFERED];
                        end
                    `TRW_OFS_BLEN:
                        if (!busy_q)
                            blen_q <= mg_blen[23:0];
                    default:
                        ;
                endcase
            end
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rv_q <= 1'b0;
            rd_q <= 32'h00000000;
            rr_q <= `TRW_RESP_OKAY;
        end
        else if (rv_q)
        begin
            if (s_axi_rready)
                rv_q <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rv_q <= 1'b1;
            rr_q <= mapped(s_axi_araddr) ? `TRW_RESP_OKAY : `TRW_RESP_SLVERR;
            case (s_axi_araddr)
                `TRW_OFS_CMD0: rd_q <= cmd0_q;
                `TRW_OFS_CMD1: rd_q <= {16'h0000, cmd1_q};
                `TRW_OFS_LMAX: rd_q <= {8'h00, lmax_q};
                `TRW_OFS_LMIN: rd_q <= {16'h0000, lmin_q};
                `TRW_OFS_MODE: rd_q <= {30'h00000000, mbuf_q, mfix_q};
                `TRW_OFS_BLEN: rd_q <= {8'h00, blen_q};
                `TRW_OFS_STAT: rd_q <= {29'h00000000, chk_q, done_q, busy_q};
                `TRW_OFS_SENSE: rd_q <= {24'h000000, val_q, fm_q, eom_q, ili_q, key_q};
                `TRW_OFS_INFO: rd_q <= info_q;
                default: rd_q <= 32'h00000000;
            endcase
        end
    end

    // one-deep output stages toward initiator and medium
    assign ini_rd_valid = ov_q;
    assign ini_rd_data = od_q;
    assign med_rd_ready = (st_q == S_RD) && !eom && (!ov_q || ini_rd_ready);
    assign med_wr_valid = mv_q;
    assign med_wr_data = md_q;
    assign med_wr_last = ml_q;
    // early warning stops intake so the pipeline can settle before status
    // intake ends once every requested block is in, so no stray byte reaches the medium
    assign ini_wr_ready = (st_q == S_WR) && !ew && (rcv_q != wtarget)
                          && (!mv_q || med_wr_ready);
    assign med_start = mst_q;
    assign med_is_write = mwr_q;
    assign cmd_busy = busy_q;
    assign cmd_check = chk_q;

    wire rd_take = med_rd_valid && med_rd_ready;
    wire wr_take = ini_wr_valid && ini_wr_ready;
    wire mw_take = mv_q && med_wr_ready;
    wire [23:0] nb = blk_q + 24'h000001;
    wire fwd = fixed ? (blk_q < cur_len) : (tot_q < xfer);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            chk_q <= 1'b0;
            ili_q <= 1'b0;
            eom_q <= 1'b0;
            fm_q <= 1'b0;
            val_q <= 1'b0;
            key_q <= `TRW_KEY_NONE;
            info_q <= 32'h00000000;
            blk_q <= 24'h000000;
            tot_q <= 24'h000000;
            good_q <= 24'h000000;
            rcv_q <= 24'h000000;
            ov_q <= 1'b0;
            od_q <= 8'h00;
            mv_q <= 1'b0;
            md_q <= 8'h00;
            ml_q <= 1'b0;
            mst_q <= 1'b0;
            mwr_q <= 1'b0;
        end
        else
        begin
            mst_q <= 1'b0;
            if (ov_q && ini_rd_ready)
                ov_q <= 1'b0;
            // completion in the same cycle as the clear still leaves done set
            if (clrdone_q)
                done_q <= 1'b0;
            case (st_q)
                S_IDLE:
                    if (start_q)
                    begin
                        busy_q <= 1'b1;
                        chk_q <= 1'b0;
                        ili_q <= 1'b0;
                        eom_q <= 1'b0;
                        fm_q <= 1'b0;
                        val_q <= 1'b0;
                        key_q <= `TRW_KEY_NONE;
                        info_q <= 32'h00000000;
                        blk_q <= 24'h000000;
                        tot_q <= 24'h000000;
                        good_q <= 24'h000000;
                        rcv_q <= 24'h000000;
                        st_q <= S_DEC;
                    end
                S_DEC:
                begin
                    st_q <= S_DRAIN;
                    if ((opcode != `TRW_OP_READ) && (opcode != `TRW_OP_WRITE))
                    begin
                        chk_q <= 1'b1;
                        key_q <= `TRW_KEY_ILLEGAL;
                    end
                    else if ((fixed != fix_mode) || (fixed && FIXED_IMPL == 0)
                             || (!fixed && VAR_IMPL == 0))
                    begin
                        chk_q <= 1'b1;
                        key_q <= `TRW_KEY_ILLEGAL;
                    end
                    else if (xfer == 24'h000000)
                        chk_q <= 1'b0;
                    else if ((opcode == `TRW_OP_WRITE) && !fixed && !len_ok)
                    begin
                        chk_q <= 1'b1;
                        key_q <= `TRW_KEY_ILLEGAL;
                    end
                    else
                    begin
                        mst_q <= 1'b1;
                        mwr_q <= (opcode == `TRW_OP_WRITE);
                        st_q <= (opcode == `TRW_OP_WRITE) ? S_WR : S_RD;
                    end
                end
                S_RD:
                    if (eom)
                    begin
                        chk_q <= 1'b1;
                        eom_q <= 1'b1;
                        key_q <= `TRW_KEY_MEDIUM;
                        val_q <= fixed;
                        info_q <= fixed ? blk_res : 32'h00000000;
                        st_q <= S_DRAIN;
                    end
                    else if (rd_take)
                    begin
                        if (med_rd_fm)
                        begin
                            chk_q <= 1'b1;
                            fm_q <= 1'b1;
                            val_q <= fixed;
                            info_q <= fixed ? blk_res : 32'h00000000;
                            st_q <= S_DRAIN;
                        end
                        else
                        begin
                            if (fwd)
                            begin
                                ov_q <= 1'b1;
                                od_q <= med_rd_data;
                                tot_q <= tot_q + 24'h000001;
                            end
                            blk_q <= med_rd_last ? 24'h000000 : nb;
                            if (med_rd_last && fixed)
                            begin
                                if (nb != cur_len)
                                begin
                                    chk_q <= 1'b1;
                                    ili_q <= 1'b1;
                                    val_q <= 1'b1;
                                    info_q <= blk_res;
                                    st_q <= S_DRAIN;
                                end
                                else
                                begin
                                    good_q <= good_q + 24'h000001;
                                    if (good_q + 24'h000001 == xfer)
                                        st_q <= S_DRAIN;
                                end
                            end
                            else if (med_rd_last)
                            begin
                                st_q <= S_DRAIN;
                                if (nb != xfer)
                                begin
                                    chk_q <= 1'b1;
                                    ili_q <= 1'b1;
                                    val_q <= 1'b1;
                                    if (nb > xfer && NEG_RESIDUE == 0)
                                        info_q <= 32'h00000000;
                                    else
                                        info_q <= {8'h00, xfer} - {8'h00, nb};
                                end
                            end
                        end
                    end
                S_WR:
                begin
                    if (wr_take)
                    begin
                        mv_q <= 1'b1;
                        md_q <= ini_wr_data;
                        ml_q <= (blk_q == wblen - 24'h000001);
                        blk_q <= (blk_q == wblen - 24'h000001) ? 24'h000000 : nb;
                        if (blk_q == wblen - 24'h000001)
                            rcv_q <= rcv_q + 24'h000001;
                    end
                    else if (mw_take)
                        mv_q <= 1'b0;
                    if (mw_take && ml_q)
                    begin
                        good_q <= good_q + 24'h000001;
                        if (good_q + 24'h000001 == wtarget)
                            st_q <= S_DRAIN;
                    end
                    else if (ew && !mv_q)
                    begin
                        chk_q <= 1'b1;
                        eom_q <= 1'b1;
                        key_q <= (med_buf_blocks != 24'h000000) ?
                                 `TRW_KEY_VOLOVF : `TRW_KEY_NONE;
                        val_q <= fixed;
                        if (!fixed)
                            info_q <= 32'h00000000;
                        else if (mbuf_q)
                            info_q <= {8'h00, xfer} - {8'h00, rcv_q}
                                      + {8'h00, med_buf_blocks};
                        else
                            info_q <= blk_res;
                        st_q <= S_DRAIN;
                    end
                end
                S_DRAIN:
                    if (!ov_q && !mv_q)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: testbench/trw_props.sv */
`timescale 1ns/1ps
module trw_props (
    input wire clk,
    input wire rst_n,
    input wire [7:0] ini_rd_data,
    input wire ini_rd_valid,
    input wire ini_rd_ready,
    input wire ini_wr_ready,
    input wire [7:0] med_wr_data,
    input wire med_wr_valid,
    input wire med_wr_last,
    input wire med_wr_ready,
    input wire med_start,
    input wire med_is_write,
    input wire cmd_busy,
    input wire cmd_check
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_START_BUSY: assert property (med_start |-> cmd_busy && $past(cmd_busy))
        else $error("start outside command");
    AST_START_PULSE: assert property (med_start |=> !med_start)
        else $error("start too wide");
    AST_RD_DIR: assert property (ini_rd_valid |-> !med_is_write)
        else $error("read during write");
    AST_WR_DIR: assert property (med_wr_valid |-> med_is_write)
        else $error("write during read");
    AST_RD_HOLD: assert property (ini_rd_valid && !ini_rd_ready |=>
        ini_rd_valid && $stable(ini_rd_data)) else $error("read byte unstable");
    AST_WR_HOLD: assert property (med_wr_valid && !med_wr_ready |=>
        med_wr_valid && $stable({med_wr_data, med_wr_last})) else $error("write byte changed");
    AST_INTAKE: assert property (ini_wr_ready |-> cmd_busy && med_is_write)
        else $error("intake outside write");
    AST_SENSE_CLR: assert property ($rose(cmd_busy) |-> ##[0:1] !cmd_check)
        else $error("stale check");
endmodule
bind trw_exec trw_props trw_props_i (.*);

/* File: testbench/trw_ini_model.sv */
`timescale 1ns/1ps
module trw_ini_model (
    input wire clk,
    input wire rst_n,
    input wire ini_rd_valid,
    output logic ini_rd_ready,
    output logic [7:0] ini_wr_data,
    output logic ini_wr_valid,
    input wire ini_wr_ready,
    output int rd_count
);
    // random stalls both ways
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ini_rd_ready <= 1'b0;
            ini_wr_valid <= 1'b0;
            ini_wr_data <= 8'h00;
            rd_count <= 0;
        end
        else
        begin
            ini_rd_ready <= $urandom_range(3) != 0;
            if (ini_rd_valid && ini_rd_ready)
                rd_count <= rd_count + 1;
            if (ini_wr_valid && ini_wr_ready)
            begin
                ini_wr_valid <= 1'b0;
                ini_wr_data <= ~ini_wr_data;
            end
            else if (!ini_wr_valid && $urandom_range(3) != 0)
            begin
                ini_wr_valid <= 1'b1;
                ini_wr_data <= ini_wr_data + 8'h3B;
            end
        end
    end
endmodule

/* File: testbench/tb_trw_exec.sv */
`timescale 1ns/1ps
`include "trw_consts.vh"
module tb_trw_exec;
    logic clk, rst_n, awv, awr, wv, wr, bv, arv, arr, rv, irv, irr, iwv, iwr;
    logic mrv, mrl, mrf, mrr, mwv, mwl, mwr, ew, eom, mst, miw, busy, cko;
    logic [7:0] awa, ara, ird, iwd, mrd;
    logic [31:0] wd, rd, rd_s, d;
    logic [1:0] br, rr, rr_s;
    logic [23:0] bufb;
    int num_errors, n_compared, rdc, mwb, mwk, nst, mi, r0, i, l, a, n, k;
    int mq[$];
    trw_exec trw_exec_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .ini_rd_data(ird),
        .ini_rd_valid(irv), .ini_rd_ready(irr), .ini_wr_data(iwd), .ini_wr_valid(iwv),
        .ini_wr_ready(iwr), .med_rd_data(mrd), .med_rd_valid(mrv), .med_rd_last(mrl),
        .med_rd_fm(mrf), .med_rd_ready(mrr), .med_wr_data(), .med_wr_valid(mwv),
        .med_wr_last(mwl), .med_wr_ready(mwr), .med_buf_blocks(bufb), .med_ew_pin(ew),
        .med_eom_pin(eom), .med_start(mst), .med_is_write(miw), .cmd_busy(busy),
        .cmd_check(cko));
    trw_ini_model trw_ini_model_i (.clk(clk), .rst_n(rst_n), .ini_rd_valid(irv),
        .ini_rd_ready(irr), .ini_wr_data(iwd), .ini_wr_valid(iwv), .ini_wr_ready(iwr),
        .rd_count(rdc));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // medium: queued block lengths, -1 is a filemark
    always @(posedge clk)
    begin
        mwr <= $urandom_range(2) != 0;
        mwb += mwv && mwr;
        mwk += mwv && mwr && mwl;
        nst += mst;
        if (mrv && mrr)
            mi = mrl ? 0 : mi + 1;
        if (mrv && mrr && mrl)
            void'(mq.pop_front());
        if ((mrv && mrr) || !mrv)
        begin
            mrv <= mq.size() != 0 && $urandom_range(3) != 0;
            mrd <= (mq.size() != 0) ? mi[7:0] ^ 8'h5A : ~mrd;
            mrf <= mq.size() != 0 && mq[0] < 0;
            mrl <= mq.size() != 0 && mq[0] <= mi + 1;
        end
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hs(ref logic rdy);
        bit ok;
        do
        begin
            @(negedge clk);
            ok = rdy;
            rd_s = rd;
            rr_s = rr;
            @(posedge clk);
        end
        while (!ok);
    endtask
    task axw(input logic [7:0] ad, input logic [31:0] dt);
        bit ka, kw;
        awa <= ad;
        wd <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(negedge clk);
            ka = !awv || awr;
            kw = !wv || wr;
            @(posedge clk);
            awv <= !ka;
            wv <= !kw;
        end
        while (!(ka && kw));
        hs(bv);
    endtask
    task axr(input logic [7:0] ad, output logic [31:0] dt);
        ara <= ad;
        arv <= 1'b1;
        hs(arr);
        arv <= 1'b0;
        hs(rv);
        dt = rd_s;
    endtask
    task cmd(input logic [7:0] op, input logic fx, input logic [23:0] cnt);
        r0 = rdc;
        mwb = 0;
        mwk = 0;
        nst = 0;
        axw(`TRW_OFS_CMD0, {cnt[15:8], cnt[23:16], 7'h00, fx, op});
        axw(`TRW_OFS_CMD1, {24'h000000, cnt[7:0]});
        axw(`TRW_OFS_CTRL, 32'h00000003);
    endtask
    task wdone;
        d = 32'h0;
        while (d[1] !== 1'b1)
            axr(`TRW_OFS_STAT, d);
    endtask
    function logic [31:0] sn(input logic [3:0] key, input logic [3:0] flg);
        return {24'h000000, flg, key};
    endfunction
    task fin(input logic [31:0] es, input logic [31:0] ei);
        wdone();
        axr(`TRW_OFS_STAT, d);
        chk("status", d, {29'h0, |es, 2'b10});
        chk("check_pin", cko, |es);
        axr(`TRW_OFS_SENSE, d);
        chk("sense", d, es);
        axr(`TRW_OFS_INFO, d);
        chk("residue", d, ei);
    endtask
    task summarize;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #400us;
        num_errors++;
        summarize();
    end
    initial
    begin
        {rst_n, awv, wv, arv, mrv, mrl, mrf, ew, eom, mwr, mi, num_errors, n_compared} = 0;
        {awa, ara, wd, mrd, bufb} = 0;
        void'($urandom(32'hE47A));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axr(`TRW_OFS_LMAX, d);
        chk("lmax", d, 32'h0);
        axr(`TRW_OFS_LMIN, d);
        chk("lmin", d, 32'h1);
        axr(`TRW_OFS_BLEN, d);
        chk("blen", d, 32'h200);
        axr(8'h28, d);
        chk("unmapped", rr_s, `TRW_RESP_SLVERR);
        for (i = 0; i < 5; i++)
        begin
            cmd(i < 2 ? 8'h10 : (i[0] ? `TRW_OP_READ : `TRW_OP_WRITE), i inside {2, 3}, (i == 4) ? 0 : 5);
            if (i < 4)
                fin(sn(`TRW_KEY_ILLEGAL, 4'h0), 32'h0);
            else
                fin(32'h0, 32'h0);
            chk("no_motion", nst + mwb, 0);
        end
        for (i = 0; i < 4; i++)
        begin
            l = $urandom_range(40, 2);
            a = i == 0 ? l : (i == 1 ? l - 1 : (i == 2 ? l + 3 : $urandom_range(50, 1)));
            mq.push_back(a);
            cmd(`TRW_OP_READ, 1'b0, l[23:0]);
            fin(a == l ? 32'h0 : sn(`TRW_KEY_NONE, 4'h9), a < l ? l - a : 0);
            chk("read_bytes", rdc - r0, a < l ? a : l);
        end
        l = $urandom_range(30, 1);
        cmd(`TRW_OP_WRITE, 1'b0, l[23:0]);
        fin(32'h0, 32'h0);
        chk("wr_bytes", mwb * 256 + mwk, l * 256 + 1);
        axw(`TRW_OFS_LMAX, 32'd16);
        axw(`TRW_OFS_LMIN, 32'd4);
        for (l = 3; l < 20; l += 14)
        begin
            cmd(`TRW_OP_WRITE, 1'b0, l[23:0]);
            fin(sn(`TRW_KEY_ILLEGAL, 4'h0), 32'h0);
            chk("refused_bytes", mwb, 0);
        end
        axw(`TRW_OFS_LMAX, 32'd4);
        cmd(`TRW_OP_READ, 1'b0, 24'd4);
        fin(sn(`TRW_KEY_ILLEGAL, 4'h0), 32'h0);
        n = $urandom_range(6, 2);
        repeat (n) mq.push_back(4);
        cmd(`TRW_OP_READ, 1'b1, n[23:0]);
        fin(32'h0, 32'h0);
        chk("fixed_bytes", rdc - r0, 4 * n);
        for (i = 0; i < 3; i++)
        begin
            k = $urandom_range(n - 1, 0);
            repeat (k) mq.push_back(4);
            if (i < 2)
                mq.push_back(i == 0 ? 5 : -1);
            cmd(`TRW_OP_READ, 1'b1, n[23:0]);
            if (i < 2)
                fin(sn(`TRW_KEY_NONE, i == 0 ? 4'h9 : 4'hC), n - k);
        end
        wait (rdc - r0 == 4 * k);
        @(posedge clk);
        eom <= 1'b1;
        fin(sn(`TRW_KEY_MEDIUM, 4'hA), n - k);
        eom <= 1'b0;
        axw(`TRW_OFS_LMAX, 32'd16);
        axw(`TRW_OFS_BLEN, 32'd8);
        axw(`TRW_OFS_MODE, 32'd1);
        cmd(`TRW_OP_WRITE, 1'b1, n[23:0]);
        fin(32'h0, 32'h0);
        chk("fixed_wr", mwb * 256 + mwk, 8 * n * 256 + n);
        bufb <= $urandom_range(3, 1);
        cmd(`TRW_OP_WRITE, 1'b1, 24'd40);
        wait (mwk >= 2);
        @(posedge clk);
        ew <= 1'b1;
        wdone();
        fin(sn(`TRW_KEY_VOLOVF, 4'hA), 40 - mwk);
        summarize();
    end
endmodule
